// ===== design/gtc_pkg.sv
// Package with register map, field positions, reset values and carriers for the gated timer
package gtc_pkg;

  // APB byte offsets
  localparam logic [7:0] GTC_OFF_TCON  = 8'h00;
  localparam logic [7:0] GTC_OFF_GCON  = 8'h04;
  localparam logic [7:0] GTC_OFF_CNTL  = 8'h08;
  localparam logic [7:0] GTC_OFF_CNTH  = 8'h0C;
  localparam logic [7:0] GTC_OFF_FLAG  = 8'h10;
  localparam logic [7:0] GTC_OFF_IEN   = 8'h14;
  localparam logic [7:0] GTC_OFF_ICTL  = 8'h18;
  localparam logic [7:0] GTC_OFF_CAPL  = 8'h1C;
  localparam logic [7:0] GTC_OFF_CAPH  = 8'h20;
  localparam logic [7:0] GTC_OFF_CCTL  = 8'h24;

  // Timer control field positions
  localparam int GTC_TC_ON    = 0;
  localparam int GTC_TC_SYNC  = 2;
  localparam int GTC_TC_OSCEN = 3;
  localparam int GTC_TC_CS0   = 6;
  // Gate control field positions
  localparam int GTC_GC_SS0   = 0;
  localparam int GTC_GC_VAL   = 2;
  localparam int GTC_GC_GO    = 3;
  localparam int GTC_GC_SPM   = 4;
  localparam int GTC_GC_TM    = 5;
  localparam int GTC_GC_POL   = 6;
  localparam int GTC_GC_GE    = 7;
  // Flag / enable positions
  localparam int GTC_FL_OVF   = 0;
  localparam int GTC_FL_GATE  = 1;
  localparam int GTC_IC_PER   = 0;
  localparam int GTC_IC_GLB   = 1;
  // Capture/compare control positions
  localparam int GTC_CC_CAPEN = 0;
  localparam int GTC_CC_CMPEN = 1;

  // Reset values and maximum counts
  localparam logic [7:0]  GTC_RST_BYTE = 8'h00;
  localparam logic [15:0] GTC_RST_CNT  = 16'h0000;
  localparam logic [15:0] GTC_CNT_MAX  = 16'hFFFF;
  localparam logic [7:0]  GTC_CMP8_MAX = 8'hFF;

  // Gate source codes
  localparam logic [1:0] GTC_GS_PIN  = 2'h0;
  localparam logic [1:0] GTC_GS_CMP8 = 2'h1;
  localparam logic [1:0] GTC_GS_CMPA = 2'h2;
  localparam logic [1:0] GTC_GS_CMPB = 2'h3;

  // Count clock source codes
  localparam logic [1:0] GTC_CS_INSTR = 2'h0;
  localparam logic [1:0] GTC_CS_SYS   = 2'h1;

  // Instruction clock is a quarter of the system clock
  localparam logic [1:0] GTC_INSTR_DIV = 2'h3;

  // Asynchronous inputs carried together
  typedef struct packed {
    logic ext_clk;
    logic gate_pin;
    logic cmp_a;
    logic cmp_b;
  } gtc_async_t;

  // Interrupt outputs carried together
  typedef struct packed {
    logic ovf_irq;
    logic gate_irq;
    logic wake;
  } gtc_irq_t;

endpackage : gtc_pkg

// ===== design/gtc_timer.sv
// Gated 16-bit timer/counter with APB register access
//
// Added by the designer: the register addresses and register access over APB.
`timescale 1ns/1ps
module gtc_timer
  import gtc_pkg::*;
(
  // Clock and reset
  input  wire logic        core_clk_i,
  input  wire logic        rstn_i,
  // APB slave
  input  wire logic        psel_i,
  input  wire logic        penable_i,
  input  wire logic        pwrite_i,
  input  wire logic [7:0]  paddr_i,
  input  wire logic [31:0] pwdata_i,
  output logic [31:0]      prdata_o,
  output logic             pready_o,
  output logic             pslverr_o,
  // Asynchronous pins and comparator outputs
  input  wire gtc_async_t  async_i,
  // Companion 8-bit timer increment strobe and value, same clock
  input  wire logic        comp8_inc_i,
  input  wire logic [7:0]  comp8_val_i,
  // Processor sleep state, same clock
  input  wire logic        sleep_i,
  // Capture event from capture unit, same clock
  input  wire logic        capture_evt_i,
  // Time base and events
  output logic [15:0]      count_o,
  output logic             compare_evt_o,
  output gtc_irq_t         irq_o
);

  // Control and status registers
  logic [7:0]  tcon_reg, tcon_next;
  logic [7:0]  gcon_reg, gcon_next;
  logic [1:0]  flag_reg, flag_next;
  logic [1:0]  ien_reg, ien_next;
  logic [1:0]  ictl_reg, ictl_next;
  logic [1:0]  cctl_reg, cctl_next;
  logic [15:0] cnt_reg, cnt_next;
  logic [15:0] ccr_reg, ccr_next;
  // Synchronizers and edge history
  logic [3:0]  s1_reg, s1_next;
  logic [3:0]  s2_reg, s2_next;
  logic        clk_prev_reg, clk_prev_next;
  logic        src_prev_reg, src_prev_next;
  logic        tog_reg, tog_next;
  logic        val_reg, val_next;
  logic        arm_reg, arm_next;
  logic [1:0]  div_reg, div_next;
  // Output registers
  logic [31:0] rdata_reg, rdata_next;
  logic        ready_reg, ready_next;
  logic        err_reg, err_next;
  logic        cmp_reg, cmp_next;
  gtc_irq_t    irq_reg, irq_next;

  // Combinational helpers
  logic        timer_on, bypass, ext_sel, ge, pol, tm, spm, go;
  logic [1:0]  gss;
  logic        ext_lvl, ext_rise, tick, src, src_rise;
  logic        gate_raw, gate_lvl, gate_ok, inc, wrap, comp8_wrap;
  logic        wr, rd, hit;

  // Field decode
  always_comb begin
    timer_on = tcon_reg[GTC_TC_ON];
    bypass   = tcon_reg[GTC_TC_SYNC];
    ext_sel  = tcon_reg[GTC_TC_CS0+1];
    ge       = gcon_reg[GTC_GC_GE];
    pol      = gcon_reg[GTC_GC_POL];
    tm       = gcon_reg[GTC_GC_TM];
    spm      = gcon_reg[GTC_GC_SPM];
    go       = gcon_reg[GTC_GC_GO];
    gss      = gcon_reg[GTC_GC_SS0 +: 2];
    wr       = psel_i && penable_i && pwrite_i && !ready_reg;
    rd       = psel_i && penable_i && !pwrite_i && !ready_reg;
  end

  // Two-stage synchronizers for every asynchronous input, bypassed by the comparator gate sources while CAPEN is clear
  always_comb begin
    s1_next = {async_i.ext_clk, async_i.gate_pin, async_i.cmp_a, async_i.cmp_b};
    s2_next = s1_reg;
  end

  // Count tick selection; bypass shortens the path by one stage only, since
  // a second clock domain is not allowed here
  always_comb begin
    ext_lvl       = bypass ? s1_reg[3] : s2_reg[3];
    clk_prev_next = ext_lvl;
    ext_rise      = ext_lvl && !clk_prev_reg;
    div_next      = div_reg + 2'h1;
    case (tcon_reg[GTC_TC_CS0 +: 2])
      GTC_CS_INSTR: tick = (div_reg == GTC_INSTR_DIV) && !sleep_i;
      GTC_CS_SYS:   tick = !sleep_i;
      default:      tick = ext_rise && (bypass || !sleep_i);
    endcase
    if (ext_sel && bypass && !s1_reg[3]) begin
      tick = tick; // Mode switch may drop or add one edge
    end
  end

  // Gate source mux, toggle and single-pulse logic
  always_comb begin
    comp8_wrap = comp8_inc_i && (comp8_val_i == GTC_CMP8_MAX);
    case (gss)
      GTC_GS_PIN:  src = s2_reg[2];
      GTC_GS_CMP8: src = comp8_wrap;
      GTC_GS_CMPA: src = cctl_reg[GTC_CC_CAPEN] ? s2_reg[1] : async_i.cmp_a;
      GTC_GS_CMPB: src = cctl_reg[GTC_CC_CAPEN] ? s2_reg[0] : async_i.cmp_b;
      default:     src = 1'b0;
    endcase
    src_prev_next = src;
    src_rise      = src && !src_prev_reg;
    tog_next      = tog_reg;
    if (!tm || !timer_on) begin
      tog_next = 1'b0;
    end else if (src_rise) begin
      tog_next = !tog_reg;
    end
    gate_raw = (tm ? tog_reg : src) ~^ pol;
    // Single pulse passes gate only while GO is set
    arm_next = arm_reg;
    if (!spm || !go) begin
      arm_next = 1'b0;
    end else if (gate_raw) begin
      arm_next = 1'b1;
    end
    gate_lvl = spm ? (go && gate_raw) : gate_raw;
    val_next = gate_lvl;
    gate_ok  = !ge || gate_lvl;
    inc      = timer_on && tick && gate_ok;
    wrap     = inc && (cnt_reg == GTC_CNT_MAX);
  end

  // Register writes, counter and flags
  always_comb begin
    tcon_next = tcon_reg;
    gcon_next = gcon_reg;
    flag_next = flag_reg;
    ien_next  = ien_reg;
    ictl_next = ictl_reg;
    cctl_next = cctl_reg;
    ccr_next  = ccr_reg;
    cnt_next  = inc ? cnt_reg + 16'h0001 : cnt_reg;
    if (wr) begin
      case (paddr_i)
        GTC_OFF_TCON: tcon_next = pwdata_i[7:0] & 8'hFD;
        GTC_OFF_GCON: gcon_next = pwdata_i[7:0] & 8'hFB;
        GTC_OFF_CNTL: cnt_next  = {cnt_reg[15:8], pwdata_i[7:0]};
        GTC_OFF_CNTH: cnt_next  = {pwdata_i[7:0], cnt_reg[7:0]};
        GTC_OFF_FLAG: flag_next = pwdata_i[1:0];
        GTC_OFF_IEN:  ien_next  = pwdata_i[1:0];
        GTC_OFF_ICTL: ictl_next = pwdata_i[1:0];
        GTC_OFF_CAPL: ccr_next  = {ccr_reg[15:8], pwdata_i[7:0]};
        GTC_OFF_CAPH: ccr_next  = {pwdata_i[7:0], ccr_reg[7:0]};
        GTC_OFF_CCTL: cctl_next = pwdata_i[1:0];
        default:      cctl_next = cctl_reg;
      endcase
    end
    // Trailing edge of captured pulse ends acquisition
    if (arm_reg && !gate_raw) begin
      gcon_next[GTC_GC_GO] = 1'b0;
    end
    if (!gcon_next[GTC_GC_SPM]) begin
      gcon_next[GTC_GC_GO] = 1'b0;
    end
    // Hardware set wins over software clear
    if (wrap) begin
      flag_next[GTC_FL_OVF] = 1'b1;
    end
    if (val_reg && !gate_lvl) begin
      flag_next[GTC_FL_GATE] = 1'b1;
    end
    // Capture copies whole count
    if (cctl_reg[GTC_CC_CAPEN] && capture_evt_i) begin
      ccr_next = cnt_reg;
    end
  end

  // Interrupt, compare and bus answer outputs
  always_comb begin
    irq_next.ovf_irq  = timer_on && flag_reg[GTC_FL_OVF] && ien_reg[GTC_FL_OVF]
                        && ictl_reg[GTC_IC_PER] && ictl_reg[GTC_IC_GLB];
    irq_next.gate_irq = flag_reg[GTC_FL_GATE] && ien_reg[GTC_FL_GATE];
    irq_next.wake     = timer_on && flag_reg[GTC_FL_OVF] && ien_reg[GTC_FL_OVF]
                        && ictl_reg[GTC_IC_PER];
    cmp_next   = cctl_reg[GTC_CC_CMPEN] && (cnt_reg == ccr_reg);
    ready_next = psel_i && penable_i && !ready_reg;
    hit        = 1'b1;
    rdata_next = 32'h0000_0000;
    case (paddr_i)
      GTC_OFF_TCON: rdata_next[7:0] = tcon_reg;
      GTC_OFF_GCON: rdata_next[7:0] = {gcon_reg[7:3], val_reg, gcon_reg[1:0]};
      GTC_OFF_CNTL: rdata_next[7:0] = cnt_reg[7:0];
      GTC_OFF_CNTH: rdata_next[7:0] = cnt_reg[15:8];
      GTC_OFF_FLAG: rdata_next[1:0] = flag_reg;
      GTC_OFF_IEN:  rdata_next[1:0] = ien_reg;
      GTC_OFF_ICTL: rdata_next[1:0] = ictl_reg;
      GTC_OFF_CAPL: rdata_next[7:0] = ccr_reg[7:0];
      GTC_OFF_CAPH: rdata_next[7:0] = ccr_reg[15:8];
      GTC_OFF_CCTL: rdata_next[1:0] = cctl_reg;
      default:      hit = 1'b0;
    endcase
    // Refused or absent read keeps the last data
    if (!rd || !hit) begin
      rdata_next = rdata_reg;
    end
    err_next = ready_next && !hit;
  end

  // State registers, synchronous active-low reset
  always_ff @(posedge core_clk_i) begin
    if (!rstn_i) begin
      tcon_reg     <= GTC_RST_BYTE;
      gcon_reg     <= GTC_RST_BYTE;
      flag_reg     <= 2'h0;
      ien_reg      <= 2'h0;
      ictl_reg     <= 2'h0;
      cctl_reg     <= 2'h0;
      cnt_reg      <= GTC_RST_CNT;
      ccr_reg      <= GTC_RST_CNT;
      s1_reg       <= 4'h0;
      s2_reg       <= 4'h0;
      clk_prev_reg <= 1'b0;
      src_prev_reg <= 1'b0;
      tog_reg      <= 1'b0;
      val_reg      <= 1'b0;
      arm_reg      <= 1'b0;
      div_reg      <= 2'h0;
      rdata_reg    <= 32'h0000_0000;
      ready_reg    <= 1'b0;
      err_reg      <= 1'b0;
      cmp_reg      <= 1'b0;
      irq_reg      <= '0;
    end else begin
      tcon_reg     <= tcon_next;
      gcon_reg     <= gcon_next;
      flag_reg     <= flag_next;
      ien_reg      <= ien_next;
      ictl_reg     <= ictl_next;
      cctl_reg     <= cctl_next;
      cnt_reg      <= cnt_next;
      ccr_reg      <= ccr_next;
      s1_reg       <= s1_next;
      s2_reg       <= s2_next;
      clk_prev_reg <= clk_prev_next;
      src_prev_reg <= src_prev_next;
      tog_reg      <= tog_next;
      val_reg      <= val_next;
      arm_reg      <= arm_next;
      div_reg      <= div_next;
      rdata_reg    <= rdata_next;
      ready_reg    <= ready_next;
      err_reg      <= err_next;
      cmp_reg      <= cmp_next;
      irq_reg      <= irq_next;
    end
  end

  // Outputs straight from flip-flops
  always_comb begin
    prdata_o      = rdata_reg;
    pready_o      = ready_reg;
    pslverr_o     = err_reg;
    count_o       = cnt_reg;
    compare_evt_o = cmp_reg;
    irq_o         = irq_reg;
  end

endmodule : gtc_timer

// ===== tb/gtc_timer_checker.sv
// Port-level assertion checker for the gated timer
`timescale 1ns/1ps
module gtc_timer_checker
  import gtc_pkg::*;
(
  // Clock, reset and bus
  input wire logic        core_clk_i,
  input wire logic        rstn_i,
  input wire logic        psel_i,
  input wire logic        penable_i,
  input wire logic        pwrite_i,
  input wire logic [31:0] prdata_o,
  input wire logic        pready_o,
  input wire logic        pslverr_o,
  // Timer side
  input wire gtc_async_t  async_i,
  input wire logic        sleep_i,
  input wire logic [15:0] count_o,
  input wire gtc_irq_t    irq_o
);
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!rstn_i);

  // Edge at which a write lands
  logic wr_take;
  assign wr_take = psel_i && penable_i && pwrite_i && !pready_o;

  // Bus handshake: exactly one wait state
  rdy_wait_a: assert property (psel_i && penable_i && !pready_o |=> pready_o)
    else $error("pready not one cycle after access");
  rdy_pulse_a: assert property (pready_o |=> !pready_o) else $error("pready held");
  rdy_src_a: assert property (pready_o |-> $past(psel_i && penable_i))
    else $error("pready without access");
  err_rdy_a: assert property (pslverr_o |-> pready_o) else $error("pslverr without pready");
  err_hold_a: assert property (pslverr_o && !pwrite_i |-> $stable(prdata_o))
    else $error("refused read changed data");
  // Count only steps by one, wrap included, unless written
  count_step_a: assert property (!$past(wr_take) |->
    count_o == $past(count_o) || count_o == 16'($past(count_o) + 16'h0001))
    else $error("count jumped");
  // No count edge in sleep means no count change
  sleep_hold_a: assert property (
    (sleep_i && !psel_i && $stable(async_i.ext_clk))[*4] |=> $stable(count_o))
    else $error("count moved in sleep");
  ovf_src_a: assert property ($rose(irq_o.ovf_irq) |-> count_o == 16'h0000 ||
    $past(count_o) == 16'h0000 || $past(wr_take) || $past(wr_take, 2))
    else $error("overflow request without cause");

  // Main scenarios reached
  ovf_c: cover property ($rose(irq_o.ovf_irq));
  err_c: cover property (pslverr_o);
  slp_c: cover property (sleep_i && $changed(count_o));
endmodule : gtc_timer_checker

bind gtc_timer gtc_timer_checker chk (.core_clk_i, .rstn_i, .psel_i, .penable_i, .pwrite_i,
  .prdata_o, .pready_o, .pslverr_o, .async_i, .sleep_i, .count_o, .irq_o);

// ===== tb/gtc_timer_test.sv
// Self-checking bench for the gated timer
`timescale 1ns/1ps
module gtc_timer_test
  import gtc_pkg::*;
;
  logic        clk, rstn, psel, pen, pwr, tinc, slp, cap, err, pready, pslverr, cmp_evt;
  logic [7:0]  paddr, tval;
  logic [15:0] cnt;
  logic [31:0] pwdata, rd, prdata, v, a;
  gtc_async_t  asy;
  gtc_irq_t    irq;
  int          errors, n_checks, cyc, i;
  int          seed = 32'h0043;

  gtc_timer uut (.core_clk_i(clk), .rstn_i(rstn), .psel_i(psel), .penable_i(pen),
    .pwrite_i(pwr), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata),
    .pready_o(pready), .pslverr_o(pslverr), .async_i(asy), .comp8_inc_i(tinc),
    .comp8_val_i(tval), .sleep_i(slp), .capture_evt_i(cap), .count_o(cnt),
    .compare_evt_o(cmp_evt), .irq_o(irq));

  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  task automatic results();
    if (errors == 0 && n_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : results

  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    n_checks++;
    if (s !== e) begin
      errors++;
      $display("MISMATCH %0t seen %h expected %h", $time, s, e);
    end
  endtask : chk

  // One APB transfer; data taken at the ready edge
  task automatic apb(input logic w, input logic [7:0] ad, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1; pwr <= w; paddr <= ad; pwdata <= d;
    @(posedge clk);
    pen <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rd = prdata; err = pslverr;
    psel <= 1'b0; pen <= 1'b0;
  endtask : apb

  // Hang guard, far above the run length
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      errors++;
      results();
    end
  end

  initial begin
    {psel, pen, pwr, tinc, slp, cap, rstn} = '0;
    {paddr, tval, pwdata} = '0;
    asy = '0;
    repeat (10) @(posedge clk);
    rstn <= 1'b1;
    apb(0, GTC_OFF_TCON, 0); chk(rd, 0);
    apb(0, 8'h30, 0); chk(err, 1);
    // Random count, captured then compared
    v = $random(seed);
    apb(1, GTC_OFF_CNTL, v[7:0]); apb(1, GTC_OFF_CNTH, v[15:8]);
    apb(1, GTC_OFF_CCTL, 1);
    cap <= 1'b1; @(posedge clk); cap <= 1'b0;
    apb(0, GTC_OFF_CAPL, 0); chk(rd, v[7:0]);
    apb(0, GTC_OFF_CAPH, 0); chk(rd, v[15:8]);
    apb(1, GTC_OFF_CCTL, 2); @(posedge clk); chk(cmp_evt, 1);
    // Overflow with the global enable withheld, then given
    apb(1, GTC_OFF_CNTL, 8'hFE); apb(1, GTC_OFF_CNTH, 8'hFF);
    apb(1, GTC_OFF_IEN, 1); apb(1, GTC_OFF_ICTL, 1); apb(1, GTC_OFF_TCON, 8'h41);
    repeat (20) @(posedge clk);
    chk(irq.ovf_irq, 0);
    apb(0, GTC_OFF_FLAG, 0); chk(rd[0], 1);
    apb(1, GTC_OFF_ICTL, 3); repeat (3) @(posedge clk); chk(irq.ovf_irq, 1);
    apb(1, GTC_OFF_FLAG, 0); @(posedge clk); chk(irq.ovf_irq, 0);
    // Gated counting for each polarity and level
    for (i = 0; i < 4; i++) begin
      asy.gate_pin <= i[0];
      apb(1, GTC_OFF_GCON, {1'b1, i[1], 6'h00});
      apb(0, GTC_OFF_CNTL, 0); a = rd;
      apb(0, GTC_OFF_CNTL, 0); chk(32'(rd != a), 32'(i[0] == i[1]));
    end
    // Each level source seen in status, falling edge flagged
    for (i = 0; i < 4; i++) if (i != 1) begin
      asy <= gtc_async_t'({1'b0, i == 0, i == 2, i == 3});
      apb(1, GTC_OFF_GCON, 8'h40 | i); apb(1, GTC_OFF_FLAG, 0);
      apb(0, GTC_OFF_GCON, 0); chk(rd[2], 1);
      asy <= '0; repeat (2) @(posedge clk);
      apb(0, GTC_OFF_GCON, 0); chk(rd[2], 0);
      apb(0, GTC_OFF_FLAG, 0); chk(rd[1], 1);
    end
    // Companion timer: only the wrap gives a pulse
    apb(1, GTC_OFF_GCON, 8'h41); apb(1, GTC_OFF_FLAG, 0);
    for (i = 0; i < 2; i++) begin
      tval <= i[0] ? GTC_CMP8_MAX : 8'h10; tinc <= 1'b1;
      @(posedge clk); tinc <= 1'b0;
      repeat (6) @(posedge clk);
      apb(0, GTC_OFF_FLAG, 0); chk(rd[1], i[0]);
    end
    // Single pulse: armed, done on trailing edge, then blocked
    apb(1, GTC_OFF_GCON, 8'hD0); apb(1, GTC_OFF_GCON, 8'hD8);
    apb(0, GTC_OFF_GCON, 0); chk(rd[3], 1);
    for (i = 0; i < 2; i++) begin
      apb(0, GTC_OFF_CNTL, 0); a = rd;
      asy.gate_pin <= 1'b1; repeat (8) @(posedge clk);
      asy.gate_pin <= 1'b0; repeat (6) @(posedge clk);
      apb(0, GTC_OFF_GCON, 0); chk(rd[3], 0);
      apb(0, GTC_OFF_CNTL, 0); chk(32'(rd != a), 32'(i == 0));
    end
    // Toggle: first source cycle opens the gate, the next closes it
    apb(1, GTC_OFF_GCON, 8'hC0); apb(1, GTC_OFF_GCON, 8'hE0);
    for (i = 0; i < 2; i++) begin
      asy.gate_pin <= 1'b1; repeat (4) @(posedge clk);
      asy.gate_pin <= 1'b0; repeat (4) @(posedge clk);
      apb(0, GTC_OFF_CNTL, 0); a = rd;
      apb(0, GTC_OFF_CNTL, 0); chk(32'(rd != a), 32'(i == 0));
    end
    // Sleep: internal clock halts, bypassed external clock runs
    apb(1, GTC_OFF_GCON, 0); slp <= 1'b1;
    apb(0, GTC_OFF_CNTL, 0); a = rd;
    apb(0, GTC_OFF_CNTL, 0); chk(rd, a);
    apb(1, GTC_OFF_TCON, 8'h84); apb(1, GTC_OFF_CNTL, 0); apb(1, GTC_OFF_CNTH, 0);
    apb(1, GTC_OFF_TCON, 8'h85);
    repeat (3) begin
      asy.ext_clk <= 1'b1; repeat (3) @(posedge clk);
      asy.ext_clk <= 1'b0; repeat (3) @(posedge clk);
    end
    chk(cnt, 3);
    results();
  end
endmodule : gtc_timer_test
